/* File: hw/trxi_defs.svh */
// opcode encodings, field positions and widths for the table-read/test/xor unit
// assumes inclusion by bare name from the package and design files
`ifndef TRXI_DEFS_SVH
`define TRXI_DEFS_SVH
`define TRXI_OPC_W 14
`define TRXI_DATA_W 8
`define TRXI_FADDR_W 7
`define TRXI_PC_W 11
`define TRXI_OP_TRD_HIGH 14'h0058
`define TRXI_OP_TRD_LOW 14'h0050
`define TRXI_ZT_MASK 14'h3F80
`define TRXI_ZT_CODE 14'h0880
`define TRXI_XL_MASK 14'h3F00
`define TRXI_XL_CODE 14'h1F00
`define TRXI_XF_MASK 14'h3F00
`define TRXI_XF_CODE 14'h0600
`define TRXI_DEST_BIT 7
`define TRXI_ROM_HI_W 6
`define TRXI_TBL_CYCLES 2'h2
`endif

/* File: hw/trxi_pkg.sv */
// types shared by the table-read/test/xor unit
// assumes trxi_defs.svh is on the include path
`include "trxi_defs.svh"
package trxi_pkg;
    typedef enum logic [2:0] {
        TRXI_OP_NONE,
        TRXI_OP_HIGH,
        TRXI_OP_LOW,
        TRXI_OP_ZT,
        TRXI_OP_XL,
        TRXI_OP_XF
    } trxi_op_t;
    typedef enum {
        TRXI_IDLE,
        TRXI_FETCH
    } trxi_state_t;
    typedef struct packed {
        logic we;
        logic [`TRXI_FADDR_W-1:0] addr;
        logic [`TRXI_DATA_W-1:0] data;
    } trxi_fwr_t;
    typedef struct packed {
        logic we;
        logic [`TRXI_DATA_W-1:0] data;
    } trxi_acc_t;
endpackage

/* File: hw/trxi_decode.sv */
// opcode classifier for the five instructions of this unit
// assumes a registered 14-bit opcode presented with a valid strobe
`timescale 1ns/1ps
`default_nettype none
`include "trxi_defs.svh"
module trxi_decode
    import trxi_pkg::*;
(
    input wire logic [`TRXI_OPC_W-1:0] opcode_in,
    output trxi_op_t op_out
);
    always_comb begin
        if (opcode_in == `TRXI_OP_TRD_HIGH) begin
            op_out = TRXI_OP_HIGH;
        end else if (opcode_in == `TRXI_OP_TRD_LOW) begin
            op_out = TRXI_OP_LOW;
        end else if ((opcode_in & `TRXI_ZT_MASK) == `TRXI_ZT_CODE) begin
            op_out = TRXI_OP_ZT;
        end else if ((opcode_in & `TRXI_XL_MASK) == `TRXI_XL_CODE) begin
            op_out = TRXI_OP_XL;
        end else if ((opcode_in & `TRXI_XF_MASK) == `TRXI_XF_CODE) begin
            op_out = TRXI_OP_XF;
        end else begin
            op_out = TRXI_OP_NONE;
        end
    end
endmodule
`default_nettype wire

/* File: hw/trxi_unit.sv */
// execution unit for table reads, zero test and the two xor instructions
// assumes file read data follows the address field of INSTR_IN in the same cycle,
// and the rom answers in the same cycle that ROM_RD_OUT and ROM_ADDR_OUT are driven
`timescale 1ns/1ps
`default_nettype none
`include "trxi_defs.svh"
// Notes on behaviour
// - high table read loads upper six bits, zero-filled, flags kept
// - low table read loads lower byte, flags kept
// - pointer is upper register over indirect register
// - zero test sets zero flag on zero
// - literal xor into acc, zero flag only
// - file xor with acc, zero flag only
// - destination bit picks acc or file
// - 7-bit file address, one destination bit
module trxi_unit
    import trxi_pkg::*;
#(
    parameter int PC_W = `TRXI_PC_W
) (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic INSTR_VALID_IN,
    input wire logic [`TRXI_OPC_W-1:0] INSTR_IN,
    input wire logic [`TRXI_DATA_W-1:0] ACC_IN,
    input wire logic [`TRXI_DATA_W-1:0] FILE_RDATA_IN,
    input wire logic [PC_W-9:0] PTR_UPPER_IN,
    input wire logic [`TRXI_DATA_W-1:0] INDIRECT_IN,
    input wire logic [`TRXI_OPC_W-1:0] ROM_DATA_IN,
    output logic [PC_W-1:0] ROM_ADDR_OUT,
    output logic ROM_RD_OUT,
    output logic BUSY_OUT,
    output logic DONE_OUT,
    output trxi_acc_t ACC_WR_OUT,
    output trxi_fwr_t FILE_WR_OUT,
    output logic ZERO_WE_OUT,
    output logic ZERO_OUT
);
    trxi_op_t op;
    trxi_state_t state, next_state;
    logic high_sel, next_high_sel;
    logic [PC_W-1:0] next_rom_addr;
    logic next_rom_rd, next_busy, next_done, next_zero_we, next_zero;
    trxi_acc_t next_acc_wr;
    trxi_fwr_t next_file_wr;
    logic [`TRXI_DATA_W-1:0] xor_res;
    logic [`TRXI_FADDR_W-1:0] faddr;
    logic dest;

    trxi_decode u_decode (
        .opcode_in(INSTR_IN),
        .op_out(op)
    );

    assign faddr = INSTR_IN[`TRXI_FADDR_W-1:0];
    assign dest = INSTR_IN[`TRXI_DEST_BIT];

    always_comb begin
        next_state = state;
        next_high_sel = high_sel;
        next_rom_addr = ROM_ADDR_OUT;
        next_rom_rd = 1'b0;
        next_busy = 1'b0;
        next_done = 1'b0;
        next_zero_we = 1'b0;
        next_zero = ZERO_OUT;
        next_acc_wr = '0;
        next_file_wr = '0;
        xor_res = '0;
        case (state)
            TRXI_IDLE: begin
                // new instructions are ignored while a table read is in flight
                if (INSTR_VALID_IN) begin
                    case (op)
                        TRXI_OP_HIGH, TRXI_OP_LOW: begin
                            next_rom_addr = {PTR_UPPER_IN, INDIRECT_IN};
                            next_rom_rd = 1'b1;
                            next_busy = 1'b1;
                            next_high_sel = (op == TRXI_OP_HIGH);
                            next_state = TRXI_FETCH;
                        end
                        TRXI_OP_ZT: begin
                            next_zero_we = 1'b1;
                            next_zero = (FILE_RDATA_IN == 8'h00);
                            next_done = 1'b1;
                        end
                        TRXI_OP_XL: begin
                            xor_res = ACC_IN ^ INSTR_IN[`TRXI_DATA_W-1:0];
                            next_acc_wr = '{we: 1'b1, data: xor_res};
                            next_zero_we = 1'b1;
                            next_zero = (xor_res == 8'h00);
                            next_done = 1'b1;
                        end
                        TRXI_OP_XF: begin
                            xor_res = ACC_IN ^ FILE_RDATA_IN;
                            if (dest) begin
                                next_file_wr = '{we: 1'b1, addr: faddr, data: xor_res};
                            end else begin
                                next_acc_wr = '{we: 1'b1, data: xor_res};
                            end
                            next_zero_we = 1'b1;
                            next_zero = (xor_res == 8'h00);
                            next_done = 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            TRXI_FETCH: begin
                // second cycle: rom word arrives, flags untouched
                if (high_sel) begin
                    next_acc_wr = '{we: 1'b1,
                        data: {2'b00, ROM_DATA_IN[`TRXI_OPC_W-1:`TRXI_DATA_W]}};
                end else begin
                    next_acc_wr = '{we: 1'b1, data: ROM_DATA_IN[`TRXI_DATA_W-1:0]};
                end
                next_done = 1'b1;
                next_state = TRXI_IDLE;
            end
            default: begin
                next_state = TRXI_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state <= TRXI_IDLE;
            high_sel <= 1'b0;
            ROM_ADDR_OUT <= '0;
            ROM_RD_OUT <= 1'b0;
            BUSY_OUT <= 1'b0;
            DONE_OUT <= 1'b0;
            ZERO_WE_OUT <= 1'b0;
            ZERO_OUT <= 1'b0;
            ACC_WR_OUT <= '0;
            FILE_WR_OUT <= '0;
        end else begin
            state <= next_state;
            high_sel <= next_high_sel;
            ROM_ADDR_OUT <= next_rom_addr;
            ROM_RD_OUT <= next_rom_rd;
            BUSY_OUT <= next_busy;
            DONE_OUT <= next_done;
            ZERO_WE_OUT <= next_zero_we;
            ZERO_OUT <= next_zero;
            ACC_WR_OUT <= next_acc_wr;
            FILE_WR_OUT <= next_file_wr;
        end
    end

    table_read_two_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        ROM_RD_OUT |=> DONE_OUT && ACC_WR_OUT.we && !ZERO_WE_OUT)
        else $error("table read did not finish in two cycles");
    table_start_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (INSTR_VALID_IN && state == TRXI_IDLE && (op == TRXI_OP_HIGH || op == TRXI_OP_LOW))
            |=> ROM_RD_OUT && !DONE_OUT && !ACC_WR_OUT.we && !ZERO_WE_OUT)
        else $error("table read start wrong");
    busy_with_fetch_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        BUSY_OUT == ROM_RD_OUT)
        else $error("busy does not match the fetch cycle");
    rom_rd_pulse_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        ROM_RD_OUT |=> !ROM_RD_OUT)
        else $error("rom read longer than one cycle");
    // a stray strobe in the fetch cycle is dropped, not queued; the core must not issue one
    fetch_refuses_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (ROM_RD_OUT && INSTR_VALID_IN) |=> !ZERO_WE_OUT && !FILE_WR_OUT.we && !ROM_RD_OUT)
        else $error("instruction taken during table fetch");
    high_zero_fill_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (ROM_RD_OUT && high_sel) |=> ACC_WR_OUT.data ==
            {2'b00, $past(ROM_DATA_IN[13:8])})
        else $error("high table read data wrong");
    low_read_data_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (ROM_RD_OUT && !high_sel) |=> ACC_WR_OUT.data == $past(ROM_DATA_IN[7:0]))
        else $error("low table read data wrong");
    table_flags_kept_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        ROM_RD_OUT |-> !ZERO_WE_OUT ##1 !ZERO_WE_OUT)
        else $error("table read touched the zero flag");
    // zero value only moves with its write pulse, so table reads cannot disturb it
    zero_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        !ZERO_WE_OUT |-> ZERO_OUT == $past(ZERO_OUT))
        else $error("zero value moved without a write");
    pointer_form_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        ROM_RD_OUT |-> ROM_ADDR_OUT == {$past(PTR_UPPER_IN), $past(INDIRECT_IN)})
        else $error("table pointer wrong");
    single_done_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (INSTR_VALID_IN && state == TRXI_IDLE
            && (op == TRXI_OP_ZT || op == TRXI_OP_XL || op == TRXI_OP_XF))
            |=> DONE_OUT && !ROM_RD_OUT && !BUSY_OUT)
        else $error("single cycle instruction not done in one cycle");
    zero_test_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (INSTR_VALID_IN && state == TRXI_IDLE && op == TRXI_OP_ZT) |=>
            ZERO_WE_OUT && ZERO_OUT == ($past(FILE_RDATA_IN) == 8'h00)
            && !ACC_WR_OUT.we && !FILE_WR_OUT.we)
        else $error("zero test wrong");
    xor_literal_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (INSTR_VALID_IN && state == TRXI_IDLE && op == TRXI_OP_XL) |=>
            ACC_WR_OUT.we && ACC_WR_OUT.data == ($past(ACC_IN) ^ $past(INSTR_IN[7:0]))
            && ZERO_OUT == (ACC_WR_OUT.data == 8'h00))
        else $error("literal xor wrong");
    xor_file_data_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (INSTR_VALID_IN && state == TRXI_IDLE && op == TRXI_OP_XF) |=>
            ZERO_WE_OUT && (FILE_WR_OUT.we ? FILE_WR_OUT.data : ACC_WR_OUT.data)
            == ($past(ACC_IN) ^ $past(FILE_RDATA_IN)))
        else $error("file xor data wrong");
    xor_file_dest_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (INSTR_VALID_IN && state == TRXI_IDLE && op == TRXI_OP_XF) |=>
            (FILE_WR_OUT.we == $past(INSTR_IN[7])) && (ACC_WR_OUT.we != FILE_WR_OUT.we)
            && DONE_OUT)
        else $error("file xor destination wrong");
    write_exclusive_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        !(ACC_WR_OUT.we && FILE_WR_OUT.we))
        else $error("acc and file written together");
    file_addr_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (INSTR_VALID_IN && state == TRXI_IDLE && op == TRXI_OP_XF && dest) |=>
            FILE_WR_OUT.addr == $past(INSTR_IN[6:0]))
        else $error("file write address wrong");
endmodule
`default_nettype wire

/* File: verif/trxi_unit_bench.sv */
// self-checking bench for the table-read/test/xor unit
// assumes trxi_pkg compiled first; bench plays acc, file and rom sources itself
`timescale 1ns/1ps
`default_nettype none
module trxi_unit_bench
    import trxi_pkg::*;
;
    logic CLK_IN;
    logic RST_N_IN;
    logic INSTR_VALID_IN;
    logic [13:0] INSTR_IN;
    logic [13:0] ROM_DATA_IN;
    logic [7:0] ACC_IN;
    logic [7:0] FILE_RDATA_IN;
    logic [7:0] INDIRECT_IN;
    logic [2:0] PTR_UPPER_IN;
    logic [10:0] ROM_ADDR_OUT;
    logic ROM_RD_OUT;
    logic BUSY_OUT;
    logic DONE_OUT;
    logic ZERO_WE_OUT;
    logic ZERO_OUT;
    trxi_acc_t ACC_WR_OUT;
    trxi_fwr_t FILE_WR_OUT;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    integer seed = 32'hCBB0A006;
    logic [31:0] k;
    logic [31:0] w;

    trxi_unit #(.PC_W(11)) DUT (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
        .INSTR_VALID_IN(INSTR_VALID_IN), .INSTR_IN(INSTR_IN), .ACC_IN(ACC_IN),
        .FILE_RDATA_IN(FILE_RDATA_IN), .PTR_UPPER_IN(PTR_UPPER_IN),
        .INDIRECT_IN(INDIRECT_IN), .ROM_DATA_IN(ROM_DATA_IN),
        .ROM_ADDR_OUT(ROM_ADDR_OUT), .ROM_RD_OUT(ROM_RD_OUT), .BUSY_OUT(BUSY_OUT),
        .DONE_OUT(DONE_OUT), .ACC_WR_OUT(ACC_WR_OUT), .FILE_WR_OUT(FILE_WR_OUT),
        .ZERO_WE_OUT(ZERO_WE_OUT), .ZERO_OUT(ZERO_OUT));

    task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // literal xor uses the low byte, everything else xors with the file operand
    function automatic logic [7:0] xor_res(logic [13:0] ins, logic [7:0] acc, logic [7:0] f);
        return (ins[13:8] == 6'h1F) ? (acc ^ ins[7:0]) : (acc ^ f);
    endfunction

    // one single-cycle instruction; results must show one edge after it is taken
    task automatic run1(input logic [13:0] ins, input logic [7:0] acc, input logic [7:0] f);
        logic [7:0] res;
        logic to_file;
        res = xor_res(ins, acc, f);
        to_file = (ins[13:8] == 6'h06) && ins[7];
        @(posedge CLK_IN);
        INSTR_VALID_IN <= 1'h1;
        INSTR_IN <= ins;
        ACC_IN <= acc;
        FILE_RDATA_IN <= f;
        @(posedge CLK_IN);
        INSTR_VALID_IN <= 1'h0;
        #1;
        chk_flag(DONE_OUT & !ROM_RD_OUT & !BUSY_OUT, 1'h1);
        chk_flag(ZERO_WE_OUT, 1'h1);
        if (ins[13:7] == 7'h11) begin
            chk_flag(ZERO_OUT, f == 8'h00);
            chk_flag(ACC_WR_OUT.we | FILE_WR_OUT.we, 1'h0);
        end else begin
            chk_flag(ZERO_OUT, res == 8'h00);
            chk_flag(ACC_WR_OUT.we, !to_file);
            chk_flag(FILE_WR_OUT.we, to_file);
            chk_data({8'h00, to_file ? FILE_WR_OUT.data : ACC_WR_OUT.data}, {8'h00, res});
            if (to_file) begin
                chk_data({9'h000, FILE_WR_OUT.addr}, {9'h000, ins[6:0]});
            end
        end
    endtask

    // opcode outside this unit's set: nothing may answer it
    task automatic run0(input logic [13:0] ins);
        @(posedge CLK_IN);
        INSTR_VALID_IN <= 1'h1;
        INSTR_IN <= ins;
        @(posedge CLK_IN);
        INSTR_VALID_IN <= 1'h0;
        #1;
        chk_flag(DONE_OUT | ROM_RD_OUT | ZERO_WE_OUT, 1'h0);
        chk_flag(ACC_WR_OUT.we | FILE_WR_OUT.we, 1'h0);
    endtask

    // two-cycle table read; bench answers as the rom, offers a stray literal xor in the
    // fetch cycle that must be refused, then scrambles its data
    task automatic tread(input logic high, input logic [2:0] up, input logic [7:0] ind,
                         input logic [13:0] word);
        logic z0;
        z0 = ZERO_OUT;
        @(posedge CLK_IN);
        INSTR_VALID_IN <= 1'h1;
        INSTR_IN <= high ? 14'h0058 : 14'h0050;
        PTR_UPPER_IN <= up;
        INDIRECT_IN <= ind;
        @(posedge CLK_IN);
        INSTR_IN <= 14'h1FFF;
        ROM_DATA_IN <= word;
        #1;
        chk_data({5'h00, ROM_ADDR_OUT}, {5'h00, up, ind});
        chk_flag(ROM_RD_OUT & BUSY_OUT & !DONE_OUT, 1'h1);
        @(posedge CLK_IN);
        INSTR_VALID_IN <= 1'h0;
        ROM_DATA_IN <= ~word;
        #1;
        chk_flag(DONE_OUT & !ROM_RD_OUT & !ZERO_WE_OUT, 1'h1);
        chk_data({7'h00, ACC_WR_OUT}, {7'h00, 1'h1, high ? {2'h0, word[13:8]} : word[7:0]});
        chk_flag(ZERO_OUT, z0);
    endtask

    initial begin
        CLK_IN = 1'h0;
        forever #2.5 CLK_IN = ~CLK_IN;
    end

    // generous ceiling: about 220 cycles of work expected
    always @(posedge CLK_IN) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("timeout at cycle %0d", cycles);
            wrap_up();
        end
    end

    initial begin
        RST_N_IN = 1'h0;
        INSTR_VALID_IN = 1'h0;
        INSTR_IN = 14'h0000;
        ACC_IN = 8'h00;
        FILE_RDATA_IN = 8'h00;
        PTR_UPPER_IN = 3'h0;
        INDIRECT_IN = 8'h00;
        ROM_DATA_IN = 14'h0000;
        repeat (12) @(posedge CLK_IN);
        RST_N_IN <= 1'h1;
        run1(14'h1FAF, 8'hB5, 8'h00);
        run1(14'h1F5A, 8'h5A, 8'h11);
        run1(14'h06FF, 8'hB5, 8'hAF);
        run1(14'h0605, 8'h3C, 8'h3C);
        run1(14'h08FF, 8'h12, 8'h00);
        run1(14'h0881, 8'h12, 8'h80);
        run0(14'h0980);
        run0(14'h0059);
        tread(1'h0, 3'h2, 8'h34, 14'h3789);
        tread(1'h1, 3'h2, 8'h34, 14'h3789);
        tread(1'h1, 3'h7, 8'hFF, 14'h3FFF);
        $display("corner tests done");
        repeat (80) begin
            k = $random(seed);
            w = $random(seed);
            case (k[1:0])
                2'h0: run1({6'h1F, w[7:0]}, w[15:8], w[23:16]);
                2'h1: run1({7'h11, w[6:0]}, w[15:8], k[3] ? 8'h00 : w[23:16]);
                2'h2: run1({6'h06, w[7:0]}, w[15:8], w[23:16]);
                default: tread(k[2], w[2:0], w[15:8], w[29:16]);
            endcase
        end
        $display("random tests done");
        wrap_up();
    end
endmodule
`default_nettype wire
